// ### fab_params.svh
/*
 * constants for the fiber auto-negotiation base-page register views:
 * register offsets, mode field codes, bit positions and fixed values.
 * assumes it is included by bare name from package and design files.
 */
`ifndef FAB_PARAMS_SVH
`define FAB_PARAMS_SVH

`define FAB_ADV_OFFSET 5'h04
`define FAB_LPA_OFFSET 5'h05
`define FAB_MODE_BASEX 2'h1
`define FAB_MODE_SYS 2'h2
`define FAB_MODE_MEDIA 2'h3
`define FAB_MEDIA_ADV 16'h0001
`define FAB_SYS_ADV_LOW 7'h01
`define FAB_ZERO16 16'h0000
`define FAB_BIT_LINK 15
`define FAB_BIT_ACK 14
`define FAB_BIT_DUPLEX 12
`define FAB_SPEED_HI 11
`define FAB_SPEED_LO 10
`define FAB_BIT_TXP 9
`define FAB_BIT_RXP 8
`define FAB_BIT_MEDIA 7
`define FAB_SPEED_10 2'h0
`define FAB_SPEED_100 2'h1
`define FAB_SPEED_1000 2'h2
`define FAB_ADDR_WIDTH 5
`define FAB_WORD_WIDTH 16
`define FAB_LOW_HI 6
`define FAB_LOW_LO 0
`define FAB_PM_BITS 3
`define FAB_SYS_LPA_KEEP 16'h7FFF
`define FAB_MEDIA_LPA_KEEP 16'hFC7F

`endif

// ### fab_pkg.sv
/*
 * types shared by both ends of the base-page register link.
 * assumes fab_params.svh is on the include path.
 */
`include "fab_params.svh"
package fab_pkg;
    typedef enum logic [1:0]
    {
        FAB_MODE_NONE,
        FAB_MODE_X,
        FAB_MODE_S,
        FAB_MODE_M
    } fab_mode_type;
    typedef logic [15:0] fab_word_type;
endpackage

// ### fab_if.sv
/*
 * link between the register bank (device) and the party that sends
 * received base pages and reads the registers (host).
 * assumes one clock shared by both ends.
 */
interface fab_if;
    import fab_pkg::*;
    logic page_valid;
    fab_word_type page_word;
    logic link_up;
    logic rd_en;
    logic wr_en;
    logic [4:0] addr;
    fab_word_type wr_data;
    fab_word_type rd_data;
    logic rd_valid;
    modport device_mp (
        input page_valid, page_word, link_up, rd_en, wr_en, addr, wr_data,
        output rd_data, rd_valid
    );
    modport host_mp (
        output page_valid, page_word, link_up, rd_en, wr_en, addr, wr_data,
        input rd_data, rd_valid
    );
endinterface

// ### fab_regs.sv
/*
 * read-only advertisement and partner ability register views, selected
 * by the two-bit mode field, with base-page capture and link-down clear.
 * assumes a single clock and synchronous inputs from the link side.
 */
// Behaviour
// - system mode adv bit15 shows copper link
// - system mode adv bit12 shows copper duplex
// - system mode adv bits11:10 show speed
// - pause and media bits zero when disabled
// - bits 9,8,7 show pauses and media
// - system mode adv bits6:0 read 0000001
// - media mode adv reads 0x0001, writes ignored
// - partner fields clear on link down, load page
// - basex partner bit15 is next page
// - partner bit14 is acknowledge
// - basex bits13:12 hold remote fault
// - basex bits8:7 hold pause ability
// - basex bits6,5 hold half/full duplex
// - partner sends basex bits4:0 as zero
// - partner sends system bits13:0 fixed pattern
// - media partner bit15 is copper link
// - media partner bit12 is duplex
// - media partner bits11:10 are speed
// - partner sends media bits6:0 as 0000001
// - partner sends media bit13 as zero
// - mode field selects register layout
`include "fab_params.svh"
module fab_regs
    import fab_pkg::*;
#(
    parameter int WORD_WIDTH = `FAB_WORD_WIDTH,
    parameter int ADDR_WIDTH = `FAB_ADDR_WIDTH
)
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic soft_reset_in,
    input wire logic [1:0] mode_in,
    input wire logic copper_link_in,
    input wire logic copper_full_duplex_in,
    input wire logic [1:0] copper_speed_in,
    input wire logic report_enable_in,
    input wire logic tx_pause_in,
    input wire logic rx_pause_in,
    input wire logic fiber_media_in,
    fab_if.device_mp link
);
    fab_word_type lpa_r;
    fab_word_type lpa_nxt;
    fab_word_type rd_data_r;
    fab_word_type rd_data_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;
    logic lpa_load;
    logic hit_adv;
    logic hit_lpa;
    fab_word_type sys_adv;
    fab_word_type adv_view;
    fab_word_type lpa_system;
    fab_word_type lpa_media;
    fab_word_type lpa_view;
    fab_word_type read_word;
    logic [`FAB_PM_BITS-1:0] pause_media_raw;
    wire logic [`FAB_PM_BITS-1:0] pause_media;

    // the views are fixed layouts, so only the documented sizes work
    if (WORD_WIDTH != `FAB_WORD_WIDTH)
    begin : g_word_check
        $error("fab_regs: register word must be 16 bits");
    end
    if (ADDR_WIDTH != `FAB_ADDR_WIDTH)
    begin : g_addr_check
        $error("fab_regs: register address must be 5 bits");
    end

    // register offset match, used for both registers
    function automatic logic addr_hit(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [ADDR_WIDTH-1:0] offset
    );
        return addr == offset;
    endfunction

    // one decode of the mode field picks the layout of either register
    function automatic fab_word_type pick_view(
        input logic [1:0] mode,
        input fab_word_type basex_word,
        input fab_word_type system_word,
        input fab_word_type media_word
    );
        fab_word_type view;
        case (mode)
            `FAB_MODE_BASEX:
            begin
                view = basex_word;
            end
            `FAB_MODE_SYS:
            begin
                view = system_word;
            end
            `FAB_MODE_MEDIA:
            begin
                view = media_word;
            end
            default:
            begin
                view = `FAB_ZERO16;
            end
        endcase
        return view;
    endfunction

    // system-mode advertisement, assembled field by field
    function automatic fab_word_type system_adv_word(
        input logic copper_up,
        input logic full_duplex,
        input logic [1:0] speed,
        input logic [`FAB_PM_BITS-1:0] pause_media_bits
    );
        fab_word_type word;
        word = `FAB_ZERO16;
        word[`FAB_BIT_LINK] = copper_up;
        word[`FAB_BIT_DUPLEX] = full_duplex;
        word[`FAB_SPEED_HI:`FAB_SPEED_LO] = speed;
        word[`FAB_BIT_TXP:`FAB_BIT_MEDIA] = pause_media_bits;
        word[`FAB_LOW_HI:`FAB_LOW_LO] = `FAB_SYS_ADV_LOW;
        return word;
    endfunction

    // reporting off forces each pause and media bit low
    assign pause_media_raw = {tx_pause_in, rx_pause_in, fiber_media_in};
    for (genvar b = 0; b < `FAB_PM_BITS; b++)
    begin : g_pause_media
        assign pause_media[b] = report_enable_in & pause_media_raw[b];
    end

    assign sys_adv = system_adv_word(copper_link_in, copper_full_duplex_in,
        copper_speed_in, pause_media);
    // basex advertisement is not kept here and reads as zero
    assign adv_view = pick_view(mode_in, `FAB_ZERO16, sys_adv,
        `FAB_MEDIA_ADV);

    // link down clears the partner word and wins over a page
    assign lpa_load = link.link_up && link.page_valid;
    assign lpa_nxt = !link.link_up ? `FAB_ZERO16 :
        (lpa_load ? link.page_word : lpa_r);

    // basex shows the whole word
    // reserved code word bits 4:0 are captured as sent
    // system hides bit 15 and keeps acknowledge and 13:0
    assign lpa_system = lpa_r & `FAB_SYS_LPA_KEEP;
    // media keeps link, ack, duplex, speed and 6:0
    assign lpa_media = lpa_r & `FAB_MEDIA_LPA_KEEP;
    assign lpa_view = pick_view(mode_in, lpa_r, lpa_system,
        lpa_media);

    // reads only sample the selected view; nothing is cleared
    assign hit_adv = addr_hit(link.addr, `FAB_ADV_OFFSET);
    assign hit_lpa = addr_hit(link.addr, `FAB_LPA_OFFSET);
    assign read_word = hit_adv ? adv_view :
        (hit_lpa ? lpa_view : `FAB_ZERO16);
    assign rd_data_nxt = link.rd_en ? read_word : rd_data_r;
    assign rd_valid_nxt = link.rd_en;
    // write strobe and data are left unread: writes are ignored

    // captured partner word
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            lpa_r <= `FAB_ZERO16;
        end
        else if (soft_reset_in)
        begin
            lpa_r <= `FAB_ZERO16;
        end
        else
        begin
            lpa_r <= lpa_nxt;
        end
    end

    // read data holds until the next read
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rd_data_r <= `FAB_ZERO16;
        end
        else if (soft_reset_in)
        begin
            rd_data_r <= `FAB_ZERO16;
        end
        else
        begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // one-cycle answer strobe
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rd_valid_r <= 1'b0;
        end
        else if (soft_reset_in)
        begin
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign link.rd_data = rd_data_r;
    assign link.rd_valid = rd_valid_r;
endmodule // fab_regs

// ### fab_partner.sv
/*
 * far end: drives link state and received base pages into the register
 * bank and issues register reads and writes for the user.
 * assumes the same clock as the device end.
 */
`include "fab_params.svh"
module fab_partner
    import fab_pkg::*;
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic link_up_in,
    input wire logic page_send_in,
    input wire logic [15:0] page_word_in,
    input wire logic rd_req_in,
    input wire logic wr_req_in,
    input wire logic [4:0] addr_in,
    input wire logic [15:0] wr_data_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    fab_if.host_mp link
);
    logic link_up_r;
    logic page_valid_r;
    fab_word_type page_word_r;
    fab_word_type rd_data_r;
    logic rd_valid_r;

    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            link_up_r <= 1'b0;
            page_valid_r <= 1'b0;
            page_word_r <= `FAB_ZERO16;
            rd_data_r <= `FAB_ZERO16;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            link_up_r <= link_up_in;
            page_valid_r <= page_send_in;
            page_word_r <= page_send_in ? page_word_in : page_word_r;
            rd_valid_r <= link.rd_valid;
            rd_data_r <= link.rd_valid ? link.rd_data : rd_data_r;
        end
    end

    // the user keeps reserved code word bits as the mode requires
    assign link.link_up = link_up_r;
    assign link.page_valid = page_valid_r;
    assign link.page_word = page_word_r;
    assign link.rd_en = rd_req_in;
    assign link.wr_en = wr_req_in;
    assign link.addr = addr_in;
    assign link.wr_data = wr_data_in;
    assign rd_data_out = rd_data_r;
    assign rd_valid_out = rd_valid_r;
endmodule // fab_partner

// ### fab_chk.sv
/* assertions on the link between the register bank and its host.
   assumes the fab_if signals, mode and reporting level, one clock. */
module fab_chk
    import fab_pkg::*;
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [1:0] mode_in,
    input wire logic report_enable_in,
    input wire logic page_valid,
    input wire fab_word_type page_word,
    input wire logic link_up,
    input wire logic rd_en,
    input wire logic [4:0] addr,
    input wire fab_word_type rd_data,
    input wire logic rd_valid
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    wire logic rd4 = rd_en && addr == 5'h04;
    wire logic rd5 = rd_en && addr == 5'h05;
    wire logic sys4 = rd4 && mode_in == 2'h2;
    AST_RDV: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    AST_RDV_IDLE: assert property (!rd_en |=> !rd_valid)
        else $error("stray read valid");
    AST_MEDIA_ADV: assert property (
        rd4 && mode_in == 2'h3 |=> rd_data == 16'h0001)
        else $error("media view wrong");
    AST_SYS_LOW: assert property (
        sys4 |=> rd_data[6:0] == 7'h01 && rd_data[14:13] == 2'h0)
        else $error("system low bits wrong");
    AST_PAUSE_OFF: assert property (
        sys4 && !report_enable_in |=> rd_data[9:7] == 3'h0)
        else $error("pause bits not forced");
    AST_CAPTURE: assert property (
        page_valid && link_up ##1
        rd5 && link_up && !page_valid && mode_in == 2'h1
        |=> rd_data == $past(page_word, 2))
        else $error("page not captured");
    AST_LINK_DOWN: assert property (
        !link_up ##1 rd5 |=> rd_data == 16'h0000)
        else $error("partner not cleared");
    AST_UNMAPPED: assert property (
        rd_en && !rd4 && !rd5 |=> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    cover property (page_valid && link_up);
    cover property (rd4 && mode_in == 2'h3);
    cover property ($fell(link_up));
endmodule // fab_chk

// ### tb_fab_regs.sv
/* bench: both ends joined by fab_if, random pages and reads.
   assumes the package, interface, both ends and the checker. */
module tb_fab_regs import fab_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, srst = 0, ren = 0, lk = 0, fd = 0, tx = 0;
    logic rx = 0, fb = 0, lu = 0, ps = 0, rq = 0, wq = 0, rv;
    logic [1:0] mode = 0, spd = 0;
    logic [4:0] ad = 0;
    logic [15:0] pw = 0, wd = 0, cap = 0, rdo;
    int errors = 0, n_compared = 0, seed = 32'h3359716A;
    fab_if link ();
    fab_regs u_fab_regs (.clock_in(clk), .arst_n_in(rst_n),
        .soft_reset_in(srst), .mode_in(mode), .copper_link_in(lk),
        .copper_full_duplex_in(fd), .copper_speed_in(spd),
        .report_enable_in(ren), .tx_pause_in(tx), .rx_pause_in(rx),
        .fiber_media_in(fb), .link(link.device_mp));
    fab_partner u_fab_partner (.clock_in(clk), .arst_n_in(rst_n),
        .link_up_in(lu), .page_send_in(ps), .page_word_in(pw),
        .rd_req_in(rq), .wr_req_in(wq), .addr_in(ad), .wr_data_in(wd),
        .rd_data_out(rdo), .rd_valid_out(rv), .link(link.host_mp));
    fab_chk u_fab_chk (.clock_in(clk), .arst_n_in(rst_n), .mode_in(mode),
        .report_enable_in(ren), .page_valid(link.page_valid),
        .page_word(link.page_word), .link_up(link.link_up),
        .rd_en(link.rd_en), .addr(link.addr), .rd_data(link.rd_data),
        .rd_valid(link.rd_valid));
    initial forever #50 clk = ~clk;
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #2ms;
        errors++;
        tally_and_finish();
    end
    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rd(logic [4:0] a, logic [15:0] e);
        ad = a;
        rq = 1;
        @(negedge clk) rq = 0;
        @(negedge clk);
        chk("rd_valid", {15'h0, rv}, 16'h0001);
        chk("rd_data", rdo, e);
    endtask
    task automatic page(logic [15:0] w);
        pw = w;
        ps = 1;
        @(negedge clk) ps = 0;
        @(negedge clk);
        if (lu) cap = w;
    endtask
    // far end keeps the fixed code word bits
    function automatic logic [15:0] shape(logic [15:0] w);
        case (mode)
            2'h1: return {w[15:5], 5'h00};
            2'h2: return {w[15:14], 14'h0001};
            2'h3: return {w[15:14], 1'b0, w[12:7], 7'h01};
            default: return w;
        endcase
    endfunction
    function automatic logic [15:0] adv();
        case (mode)
            2'h3: return 16'h0001;
            2'h2: return {lk, 2'h0, fd, spd, ren ? {tx, rx, fb} : 3'h0, 7'h01};
            default: return 16'h0000;
        endcase
    endfunction
    function automatic logic [15:0] lpa();
        case (mode)
            2'h1: return cap;
            2'h2: return {1'b0, cap[14:0]};
            2'h3: return {cap[15:10], 3'h0, cap[6:0]};
            default: return 16'h0000;
        endcase
    endfunction
    initial
    begin
        repeat (16) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        rd(5'h05, 16'h0000);
        lu = 1;
        for (int i = 0; i < 300; i++)
        begin
            {mode, spd, lk, fd, ren, tx, rx, fb} = 10'($random(seed));
            page(shape(16'($random(seed))));
            rd(5'h05, lpa());
            rd(5'h05, lpa());
            rd(5'h04, adv());
            wd = 16'($random(seed));
            ad = 5'h04 + 5'(i & 1);
            wq = 1;
            @(negedge clk) wq = 0;
            rd(ad, ad[0] ? lpa() : adv());
            rd(5'($random(seed)) | 5'h08, 16'h0000);
            if (i % 8 == 0)
            begin
                lu = 0;
                cap = 16'h0000;
                page(16'hFFFF);
                rd(5'h05, lpa());
                lu = 1;
            end
        end
        srst = 1;
        @(negedge clk) srst = 0;
        cap = 16'h0000;
        rd(5'h05, lpa());
        tally_and_finish();
    end
endmodule // tb_fab_regs
